/* cppte_ext.v */
// Summary of operation
// RL1: Trace bit 3 is high while an idle-mode request is pending.
// RL2: Trace bit 2 is high in a cycle an interrupt is accepted.
// RL3: Trace bit 1 high while fetching into queue and PC will change.
// RL4: Trace bit 0 high one cycle before a new instruction starts.
// RL5: Six dedicated external interrupt inputs, separate from port pins.
// RL6: Thirty-two port bits as four 8-bit ports, each with in/out/dir.
// RL7: Each port direction bus comes straight from its direction register.
// RL8: Direction registers decoded at consecutive addresses, port 0 lowest.
// RL9: Direction bit one means input sampled; zero means driven from output.
// RL10: Two data pointers; select register picks the one all uses see.
// RL11: Pointer select register decoded at its address, readable and writable.
// RL12: Unused opcode decodes as a trap raising a software interrupt.
// RL13: Select bit 0 picks pointer, zero first; other bits read zero.
// RL14: Reset clears pointer select and sets all direction bits to one.
// RL15: Trap vectors to a fixed address; its entry flagged on trace bit 2.
`timescale 1ns/1ps
`include "cppte_map.vh"

module cppte_ext #(
	parameter NPORT = 4,
	parameter PW    = 8
) (
	input  wire        I_MCLK,
	input  wire        I_RSTN,
	input  wire [7:0]  I_SFR_ADDR,
	input  wire [7:0]  I_SFR_WDATA,
	input  wire        I_SFR_WR,
	input  wire        I_SFR_RD,
	output wire [7:0]  O_SFR_RDATA,
	output wire        O_SFR_HIT,
	input  wire [7:0]  I_PORT0_IN,
	input  wire [7:0]  I_PORT1_IN,
	input  wire [7:0]  I_PORT2_IN,
	input  wire [7:0]  I_PORT3_IN,
	output wire [7:0]  O_PORT0_OUT,
	output wire [7:0]  O_PORT1_OUT,
	output wire [7:0]  O_PORT2_OUT,
	output wire [7:0]  O_PORT3_OUT,
	output wire [7:0]  O_PORT0_DIR,
	output wire [7:0]  O_PORT1_DIR,
	output wire [7:0]  O_PORT2_DIR,
	output wire [7:0]  O_PORT3_DIR,
	input  wire        I_PTR_LOAD,
	input  wire [15:0] I_PTR_LOAD_VAL,
	input  wire        I_PTR_INC,
	output wire [15:0] O_PTR,
	output wire        O_PTR_SEL,
	input  wire [5:0]  I_EXT_IRQ,
	output wire [5:0]  O_IRQ_REQ,
	input  wire        I_OPCODE_VALID,
	input  wire [7:0]  I_OPCODE,
	output wire        O_TRAP_REQ,
	output wire [15:0] O_TRAP_VECTOR,
	input  wire        I_IDLE_PEND,
	input  wire        I_IRQ_ACCEPT,
	input  wire        I_FETCH_PC_CHG,
	input  wire        I_START_EARLY,
	output wire [3:0]  O_TRACE_STATUS
);

	localparam W = NPORT * PW;

	// Flattened views of the four ports so one loop serves them all.
	wire [W-1:0]  port_in_w;
	reg  [W-1:0]  dir_r;
	reg  [W-1:0]  dir_nxt;
	reg  [W-1:0]  latch_r;
	reg  [W-1:0]  latch_nxt;
	reg  [W-1:0]  pout_r;
	wire [NPORT-1:0] dir_hit_w;
	wire [NPORT-1:0] latch_hit_w;
	wire [7:0]    latch_addr_w [0:NPORT-1];
	wire [7:0]    dir_addr_w [0:NPORT-1];
	reg  [PW-1:0] port_view_w [0:NPORT-1];

	reg  [15:0]   ptr_r [0:1];
	reg  [15:0]   ptr_nxt0;
	reg  [15:0]   ptr_nxt1;
	reg           sel_r;
	reg           sel_nxt;
	reg  [15:0]   optr_r;
	reg  [7:0]    rdata_r;
	reg  [7:0]    rdata_nxt;
	reg           hit_r;
	reg           hit_nxt;
	reg  [5:0]    irq_r;
	reg           trap_r;
	reg  [3:0]    trace_r;
	reg  [15:0]   sel_ptr_w;
	wire          trap_w;
	reg  [15:0]   trap_vec_r;
	integer       k;
	integer       m;

	assign port_in_w = {I_PORT3_IN, I_PORT2_IN, I_PORT1_IN, I_PORT0_IN};
	assign latch_addr_w[0] = `CPPTE_ADDR_P0_LATCH;
	assign latch_addr_w[1] = `CPPTE_ADDR_P1_LATCH;
	assign latch_addr_w[2] = `CPPTE_ADDR_P2_LATCH;
	assign latch_addr_w[3] = `CPPTE_ADDR_P3_LATCH;
	// Direction registers sit at consecutive addresses, port 0 lowest.
	assign dir_addr_w[0] = `CPPTE_ADDR_PORT0_DIRECTION; // [RL8]
	assign dir_addr_w[1] = `CPPTE_ADDR_PORT1_DIRECTION; // [RL8]
	assign dir_addr_w[2] = `CPPTE_ADDR_PORT2_DIRECTION; // [RL8]
	assign dir_addr_w[3] = `CPPTE_ADDR_PORT3_DIRECTION; // [RL8]

	// Per-port address decode and the value a read of the port returns.
	genvar g;
	generate
		for (g = 0; g < NPORT; g = g + 1) begin : gport
			assign dir_hit_w[g] = (I_SFR_ADDR == dir_addr_w[g]); // [RL8]
			assign latch_hit_w[g] = (I_SFR_ADDR == latch_addr_w[g]);
			// Input bits show the pad, output bits show the latch.
			always @* begin
				port_view_w[g] = (dir_r[g*PW +: PW] &
					port_in_w[g*PW +: PW]) |
					(~dir_r[g*PW +: PW] &
					latch_r[g*PW +: PW]); // [RL9]
			end
		end
	endgenerate

	// Register writes; other bits of the select register are not stored.
	always @* begin
		dir_nxt   = dir_r;
		latch_nxt = latch_r;
		sel_nxt   = sel_r;
		for (k = 0; k < NPORT; k = k + 1) begin
			if (I_SFR_WR && dir_hit_w[k]) begin
				dir_nxt[k*PW +: PW] = I_SFR_WDATA; // [RL8]
			end
			if (I_SFR_WR && latch_hit_w[k]) begin
				latch_nxt[k*PW +: PW] = I_SFR_WDATA;
			end
		end
		if (I_SFR_WR && I_SFR_ADDR == `CPPTE_ADDR_PTR_SEL) begin
			sel_nxt = I_SFR_WDATA[`CPPTE_PTR_SEL_BIT]; // [RL11] [RL13]
		end
	end

	// Only the selected pointer moves; the other keeps its value.
	always @* begin
		sel_ptr_w = sel_r ? ptr_r[1] : ptr_r[0]; // [RL10] [RL13]
		ptr_nxt0  = ptr_r[0];
		ptr_nxt1  = ptr_r[1];
		if (I_PTR_LOAD) begin
			sel_ptr_w = I_PTR_LOAD_VAL;
		end else if (I_PTR_INC) begin
			sel_ptr_w = sel_ptr_w + 16'h0001;
		end else if (I_SFR_WR && I_SFR_ADDR == `CPPTE_ADDR_PTR_LO) begin
			sel_ptr_w = {sel_ptr_w[15:8], I_SFR_WDATA};
		end else if (I_SFR_WR && I_SFR_ADDR == `CPPTE_ADDR_PTR_HI) begin
			sel_ptr_w = {I_SFR_WDATA, sel_ptr_w[7:0]};
		end
		if (sel_r) begin
			ptr_nxt1 = sel_ptr_w; // [RL10]
		end else begin
			ptr_nxt0 = sel_ptr_w; // [RL10]
		end
	end

	// Read mux; reads are registered so the answer comes one cycle later.
	always @* begin
		rdata_nxt = 8'h00;
		hit_nxt   = 1'b0;
		// Unmapped addresses answer zero with no hit.
		for (m = 0; m < NPORT; m = m + 1) begin
			if (dir_hit_w[m]) begin
				rdata_nxt = dir_r[m*PW +: PW];
				hit_nxt   = 1'b1;
			end
			if (latch_hit_w[m]) begin
				rdata_nxt = port_view_w[m]; // [RL9]
				hit_nxt   = 1'b1;
			end
		end
		case (I_SFR_ADDR)
		`CPPTE_ADDR_PTR_SEL: begin
			rdata_nxt = {7'h00, sel_r}; // [RL11] [RL13]
			hit_nxt   = 1'b1;
		end
		`CPPTE_ADDR_PTR_LO: begin
			rdata_nxt = sel_r ? ptr_r[1][7:0] : ptr_r[0][7:0];
			hit_nxt   = 1'b1;
		end
		`CPPTE_ADDR_PTR_HI: begin
			rdata_nxt = sel_r ? ptr_r[1][15:8] : ptr_r[0][15:8];
			hit_nxt   = 1'b1;
		end
		default: begin
			rdata_nxt = rdata_nxt;
		end
		endcase
		if (!I_SFR_RD) begin
			rdata_nxt = 8'h00;
			hit_nxt   = 1'b0;
		end
	end

	// The trap is the one opcode the base instruction set leaves unused.
	// Only a strobed opcode counts, so a stale opcode bus cannot trap again.
	assign trap_w = I_OPCODE_VALID &&
		(I_OPCODE == `CPPTE_TRAP_OPCODE); // [RL12]

	// Port registers; direction starts as input so no pad fights at power-up.
	always @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			dir_r   <= {NPORT{`CPPTE_DIR_RESET}}; // [RL14]
			latch_r <= {NPORT{`CPPTE_LATCH_RESET}};
			pout_r  <= {NPORT{`CPPTE_LATCH_RESET}};
		end else begin
			dir_r   <= dir_nxt; // [RL7]
			latch_r <= latch_nxt;
			// The pad copy takes the next latch value, so it moves in the
			// same cycle as the latch and never lags a write by a cycle.
			pout_r  <= latch_nxt; // [RL9]
		end
	end

	// Pointer registers and the select bit.
	always @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			sel_r    <= `CPPTE_PTR_SEL_RESET; // [RL14]
			ptr_r[0] <= 16'h0000;
			ptr_r[1] <= 16'h0000;
			optr_r   <= 16'h0000;
		end else begin
			sel_r    <= sel_nxt; // [RL13]
			ptr_r[0] <= ptr_nxt0;
			ptr_r[1] <= ptr_nxt1;
			// Output follows the pointer that is selected next cycle, so a
			// select write and a load in one cycle show a consistent value.
			optr_r   <= sel_nxt ? ptr_nxt1 : ptr_nxt0; // [RL10]
		end
	end

	// Registered read answer; it stands for one cycle only, so the core
	// must take it in the cycle after its read request.
	always @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			rdata_r <= 8'h00;
			hit_r   <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			hit_r   <= hit_nxt;
		end
	end

	// Interrupt lines are normalised to active high so the core sees one
	// polarity. Lines 0 and 1 idle high, the other four idle low. There is
	// no edge detection here; the core applies its own trigger mode.
	always @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			irq_r <= 6'h00;
		end else begin
			irq_r <= {I_EXT_IRQ[5:2], ~I_EXT_IRQ[1:0]}; // [RL5]
		end
	end

	// Trap request and its entry vector. The vector is held in a register
	// only so that every output of the block leaves from a flip-flop; it
	// costs sixteen flops but keeps the output timing uniform.
	always @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			trap_r     <= 1'b0;
			trap_vec_r <= `CPPTE_TRAP_VECTOR;
		end else begin
			trap_r     <= trap_w; // [RL12] [RL15]
			trap_vec_r <= `CPPTE_TRAP_VECTOR; // [RL15]
		end
	end

	// Trace status for the external monitor. The core raises its inputs one
	// cycle early, so the register delay lines each bit up with its event.
	// A trap entry is reported as an accepted interrupt on bit 2.
	always @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			trace_r <= 4'h0;
		end else begin
			trace_r[`CPPTE_TR_IDLE]  <= I_IDLE_PEND; // [RL1]
			trace_r[`CPPTE_TR_IRQ]   <= I_IRQ_ACCEPT |
				trap_w; // [RL2] [RL15]
			trace_r[`CPPTE_TR_FETCH] <= I_FETCH_PC_CHG; // [RL3]
			trace_r[`CPPTE_TR_START] <= I_START_EARLY; // [RL4]
		end
	end

	// Outputs straight from flip-flops.
	assign O_PORT0_DIR    = dir_r[0*PW +: PW]; // [RL7]
	assign O_PORT1_DIR    = dir_r[1*PW +: PW]; // [RL7]
	assign O_PORT2_DIR    = dir_r[2*PW +: PW]; // [RL7]
	assign O_PORT3_DIR    = dir_r[3*PW +: PW]; // [RL7]
	assign O_PORT0_OUT    = pout_r[0*PW +: PW]; // [RL6]
	assign O_PORT1_OUT    = pout_r[1*PW +: PW]; // [RL6]
	assign O_PORT2_OUT    = pout_r[2*PW +: PW]; // [RL6]
	assign O_PORT3_OUT    = pout_r[3*PW +: PW]; // [RL6]
	assign O_SFR_RDATA    = rdata_r;
	assign O_SFR_HIT      = hit_r;
	assign O_PTR          = optr_r;
	assign O_PTR_SEL      = sel_r;
	assign O_IRQ_REQ      = irq_r;
	assign O_TRAP_REQ     = trap_r;
	// Fixed vector; the core pushes the return address as for any interrupt.
	assign O_TRAP_VECTOR  = trap_vec_r; // [RL15]
	assign O_TRACE_STATUS = trace_r;

endmodule

/* cppte_map.vh */
`ifndef CPPTE_MAP_VH
`define CPPTE_MAP_VH

// Special function register offsets.
`define CPPTE_ADDR_P0_LATCH   8'h80
`define CPPTE_ADDR_PTR_LO     8'h82
`define CPPTE_ADDR_PTR_HI     8'h83
`define CPPTE_ADDR_P1_LATCH   8'h90
`define CPPTE_ADDR_PTR_SEL    8'h92
`define CPPTE_ADDR_P2_LATCH   8'ha0
`define CPPTE_ADDR_PORT0_DIRECTION     8'ha4
`define CPPTE_ADDR_PORT1_DIRECTION     8'ha5
`define CPPTE_ADDR_PORT2_DIRECTION     8'ha6
`define CPPTE_ADDR_PORT3_DIRECTION     8'ha7
`define CPPTE_ADDR_P3_LATCH   8'hb0

// Field positions and reset values.
`define CPPTE_PTR_SEL_BIT     0
`define CPPTE_DIR_RESET       8'hff
`define CPPTE_LATCH_RESET     8'hff
`define CPPTE_PTR_SEL_RESET   1'b0

// Trace status bit positions.
`define CPPTE_TR_IDLE         3
`define CPPTE_TR_IRQ          2
`define CPPTE_TR_FETCH        1
`define CPPTE_TR_START        0

// Trap opcode and its entry vector.
`define CPPTE_TRAP_OPCODE     8'ha5
`define CPPTE_TRAP_VECTOR     16'h0033

// External interrupt inputs; the two lowest are active low.
`define CPPTE_NUM_IRQ         6

`endif

/* cppte_ext_properties.sv */
`timescale 1ns/1ps
module cppte_ext_props (
	input wire       I_MCLK, I_RSTN, I_SFR_WR, I_SFR_RD, O_SFR_HIT,
	input wire       O_PTR_SEL, O_TRAP_REQ, I_OPCODE_VALID, I_IDLE_PEND,
	input wire       I_IRQ_ACCEPT, I_FETCH_PC_CHG, I_START_EARLY,
	input wire [7:0] I_SFR_ADDR, I_SFR_WDATA, O_SFR_RDATA, O_PORT0_DIR,
	input wire [7:0] I_OPCODE,
	input wire [5:0] I_EXT_IRQ, O_IRQ_REQ,
	input wire [3:0] O_TRACE_STATUS
);
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (!I_RSTN);
	// A trap entry shares trace bit 2 with accepted interrupts.
	wire trap = I_OPCODE_VALID && I_OPCODE == 8'ha5;
	wire sel_w = I_SFR_WR && I_SFR_ADDR == 8'h92;
	property p_idle; O_TRACE_STATUS[3] == $past(I_IDLE_PEND); endproperty
	a_idle: assert property (p_idle) else $error("idle bit");
	property p_irq; O_TRACE_STATUS[2] == $past(I_IRQ_ACCEPT | trap);
	endproperty
	a_irq: assert property (p_irq) else $error("irq bit");
	property p_fetch; $rose(O_TRACE_STATUS[1]) |-> $past(I_FETCH_PC_CHG);
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch bit");
	property p_start; I_START_EARLY |=> O_TRACE_STATUS[0]; endproperty
	a_start: assert property (p_start) else $error("start bit");
	property p_trap; O_TRAP_REQ == $past(trap); endproperty
	a_trap: assert property (p_trap) else $error("trap pulse");
	property p_sel; sel_w |=> O_PTR_SEL == $past(I_SFR_WDATA[0]);
	endproperty
	a_sel: assert property (p_sel) else $error("select bit");
	property p_dir; I_SFR_WR && I_SFR_ADDR == 8'ha4 |=>
		O_PORT0_DIR == $past(I_SFR_WDATA); endproperty
	a_dir: assert property (p_dir) else $error("dir bus");
	property p_rd; I_SFR_RD && I_SFR_ADDR == 8'h92 |=>
		O_SFR_HIT && O_SFR_RDATA[7:1] == 7'h00; endproperty
	a_rd: assert property (p_rd) else $error("select read");
	property p_ext; O_IRQ_REQ == $past({I_EXT_IRQ[5:2], ~I_EXT_IRQ[1:0]});
	endproperty
	a_ext: assert property (p_ext) else $error("irq lines");
	cover property (O_TRAP_REQ);
	cover property (sel_w ##1 O_PTR_SEL);
	cover property (I_SFR_RD && I_SFR_ADDR == 8'h92 ##1 O_SFR_HIT);
endmodule
bind cppte_ext cppte_ext_props i_props (.*);

/* cppte_pads.sv */
`timescale 1ns/1ps
module cppte_pads (
	input  wire [31:0] i_dir,
	input  wire [31:0] i_out,
	input  wire [31:0] i_ext,
	output wire [31:0] o_in
);
	// An input bit sees the outside driver, an output bit its own drive.
	assign o_in = (i_dir & i_ext) | (~i_dir & i_out);
endmodule

/* tb_cpu_port_pointer_trace_ext.sv */
`timescale 1ns/1ps
module tb_cpu_port_pointer_trace_ext;
	logic I_MCLK = 0, I_RSTN = 0, I_SFR_WR = 0, I_SFR_RD = 0;
	logic I_PTR_LOAD = 0, I_PTR_INC = 0, I_OPCODE_VALID = 0;
	logic I_IDLE_PEND = 0, I_IRQ_ACCEPT = 0, I_FETCH_PC_CHG = 0;
	logic I_START_EARLY = 0;
	logic [7:0] I_SFR_ADDR = 0, I_SFR_WDATA = 0, I_OPCODE = 0;
	logic [15:0] I_PTR_LOAD_VAL = 0;
	logic [5:0] I_EXT_IRQ = 6'h03;
	int failures = 0, checks_done = 0, k;
	wire [7:0] I_PORT0_IN, I_PORT1_IN, I_PORT2_IN, I_PORT3_IN, O_SFR_RDATA;
	wire [7:0] O_PORT0_OUT, O_PORT1_OUT, O_PORT2_OUT, O_PORT3_OUT;
	wire [7:0] O_PORT0_DIR, O_PORT1_DIR, O_PORT2_DIR, O_PORT3_DIR;
	wire [15:0] O_PTR, O_TRAP_VECTOR;
	wire [5:0] O_IRQ_REQ;
	wire [3:0] O_TRACE_STATUS;
	wire O_SFR_HIT, O_PTR_SEL, O_TRAP_REQ;
	wire [31:0] dirs = {O_PORT3_DIR, O_PORT2_DIR, O_PORT1_DIR, O_PORT0_DIR};
	cppte_ext i_dut (.*);
	// The outside world drives a fixed pattern onto pads set as inputs.
	cppte_pads i_pads (.i_dir(dirs), .i_ext(32'hc33c5aa5),
		.i_out({O_PORT3_OUT, O_PORT2_OUT, O_PORT1_OUT, O_PORT0_OUT}),
		.o_in({I_PORT3_IN, I_PORT2_IN, I_PORT1_IN, I_PORT0_IN}));
	always #2.5 I_MCLK = ~I_MCLK;
	task chk(input string n, input logic [31:0] s, e);
		checks_done++;
		if (s !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	// Each strobe is held to the edge that takes it, then dropped.
	task wr(input [7:0] a, v);
		@(posedge I_MCLK);
		I_SFR_ADDR <= a;
		I_SFR_WDATA <= v;
		I_SFR_WR <= 1;
		@(posedge I_MCLK);
		I_SFR_WR <= 0;
		#1;
	endtask
	task rd(input [7:0] a, input [8:0] e, input string n);
		@(posedge I_MCLK);
		I_SFR_ADDR <= a;
		I_SFR_RD <= 1;
		@(posedge I_MCLK);
		I_SFR_RD <= 0;
		#1 chk(n, {O_SFR_HIT, O_SFR_RDATA}, e);
	endtask
	task pl(input [15:0] v);
		@(posedge I_MCLK);
		I_PTR_LOAD <= 1;
		I_PTR_LOAD_VAL <= v;
		@(posedge I_MCLK);
		I_PTR_LOAD <= 0;
		#1;
	endtask
	task op(input [7:0] v);
		@(posedge I_MCLK);
		I_OPCODE_VALID <= 1;
		I_OPCODE <= v;
		@(posedge I_MCLK);
		I_OPCODE_VALID <= 0;
		#1;
	endtask
	task t_reset;
		chk("dir", dirs[15:0] & dirs[31:16], 16'hffff);
		chk("sel", O_PTR_SEL, 0);
		rd(8'ha7, 9'h1ff, "dir3_rd");
		rd(8'h92, 9'h100, "sel_rd");
		$display("reset test done");
	endtask
	task t_dir;
		for (k = 0; k < 4; k++) wr(8'ha4 + k[7:0], 8'h0f + k[7:0]);
		chk("dirs", dirs, 32'h1211100f);
		rd(8'ha6, 9'h111, "dir2_rd");
		rd(8'h80, 9'h1f5, "pad0_rd");
		rd(8'h93, 9'h000, "unmapped");
		$display("direction test done");
	endtask
	task t_ptr;
		wr(8'h92, 8'hff);
		rd(8'h92, 9'h101, "sel_mask");
		pl(16'h1234);
		wr(8'h92, 8'h00);
		pl(16'h5678);
		chk("ptr0", O_PTR, 16'h5678);
		wr(8'h92, 8'h01);
		chk("ptr1", O_PTR, 16'h1234);
		@(posedge I_MCLK);
		I_PTR_INC <= 1;
		@(posedge I_MCLK);
		I_PTR_INC <= 0;
		#1 chk("inc", O_PTR, 16'h1235);
		wr(8'h83, 8'hab);
		rd(8'h82, 9'h135, "ptr_lo");
		rd(8'h83, 9'h1ab, "ptr_hi");
		wr(8'h92, 8'h00);
		chk("ptr0_kept", O_PTR, 16'h5678);
		$display("pointer test done");
	endtask
	// Port 1 has only bit 4 as input here, so the read mixes pad and latch.
	task t_latch;
		wr(8'h90, 8'hc3);
		chk("out1", O_PORT1_OUT, 8'hc3);
		rd(8'h90, 9'h1d3, "pad1_rd");
		$display("latch test done");
	endtask
	task t_trap;
		op(8'ha5);
		chk("trap", {O_TRAP_REQ, O_TRACE_STATUS}, 5'h14);
		chk("vec", O_TRAP_VECTOR, 16'h0033);
		op(8'ha4);
		chk("no_trap", {O_TRAP_REQ, O_TRACE_STATUS}, 5'h00);
		$display("trap test done");
	endtask
	// One trace input and one interrupt line at a time, both polarities.
	task t_trace;
		for (k = 0; k < 6; k++) begin
			@(posedge I_MCLK);
			{I_IDLE_PEND, I_IRQ_ACCEPT, I_FETCH_PC_CHG,
				I_START_EARLY} <= 4'h8 >> k;
			I_EXT_IRQ <= 6'h03 ^ (6'h01 << k);
			@(posedge I_MCLK);
			#1 chk("trace", O_TRACE_STATUS, 4'h8 >> k);
			chk("irq", O_IRQ_REQ, {6'h01 << k});
		end
		$display("trace test done");
	endtask
	initial begin
		repeat (3) @(posedge I_MCLK);
		I_RSTN <= 1;
		t_reset;
		t_dir;
		t_latch;
		t_ptr;
		t_trap;
		t_trace;
		finish_test;
	end
	initial begin
		#20000;
		failures++;
		finish_test;
	end
	task finish_test;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
endmodule
